// ===== hw/sleep_and_watchdog_control.sv
// Sleep sequencing and watchdog timer with its control and status registers.
// Assumes all inputs are synchronous to CLK and the low-frequency tick is one CLK cycle wide.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "sleep_wdt_defines.svh"

module sleep_and_watchdog_control (
    // Clock and reset
    input  wire logic                    CLK,
    input  wire logic                    SYS_RST,
    // Register port
    input  wire sleep_wdt_pkg::reg_req_s REG_REQ,
    output logic [7:0]                   REG_RDATA,
    // Core instruction events
    input  wire logic                    SLEEP_EXEC,
    input  wire logic                    CLEAR_WATCHDOG_INSTR_EXEC,
    // Interrupt state
    input  wire logic [7:0]              IRQ_FLAGS,
    input  wire logic [7:0]              IRQ_ENABLES,
    input  wire logic                    GLOBAL_IRQ_ENABLE,
    // Configuration and clock status
    input  wire logic [1:0]              WATCHDOG_MODE_CFG,
    input  wire logic                    XTAL_MODE,
    input  wire logic                    LOW_FREQ_OSC_TICK,
    input  wire logic                    OSC_FAIL,
    // Reset sources
    input  wire logic                    POWERON_RESET,
    input  wire logic                    BROWNOUT_RESET,
    input  wire logic                    BROWNOUT_RESET_EN,
    input  wire logic                    EXTERNAL_RESET_PIN,
    input  wire logic                    EXTERNAL_RESET_EN,
    // Port drive from the core
    input  wire logic [7:0]              IO_OUT_CORE,
    input  wire logic [7:0]              IO_OE_CORE,
    // Port drive to the pads
    output logic [7:0]                   IO_OUT,
    output logic [7:0]                   IO_OE,
    // Core control
    output logic                         CORE_CLK_EN,
    output logic                         LOW_FREQ_OSC_RUN,
    output logic                         SECONDARY_OSC_RUN,
    output logic                         DEVICE_RESET,
    output logic                         WAKE,
    output logic                         ISR_CALL,
    output logic [15:0]                  ISR_VECTOR
);

    localparam logic [10:0] OST_LOAD = 11'(`OST_CYCLES - 1);

    localparam sleep_wdt_pkg::state_s RST_STATE = '{
        st:              sleep_wdt_pkg::ST_AWAKE,
        wdt_cnt:         24'h000000,
        ost_cnt:         11'h000,
        period_sel:      `WDT_PERIOD_DEFAULT,
        sw_enable:       1'b0,
        timeout_flag:    1'b1,
        power_down_flag: 1'b1,
        arith_flags:     3'h0,
        io_out:          8'h00,
        io_oe:           8'h00,
        rdata:           8'h00,
        dev_rst:         1'b0,
        wake:            1'b0,
        isr_call:        1'b0,
        core_clk_en:     1'b1,
        osc_run:         1'b1
    };

    sleep_wdt_pkg::state_s s;
    sleep_wdt_pkg::state_s next_s;

    logic        irq_pending;
    logic        hard_reset;
    logic        ext_reset;
    logic        any_reset;
    logic        wdt_active;
    logic        wdt_timeout;
    logic        wdt_clear;
    logic        sleep_nop;
    logic [23:0] prescale;

    // Prescale ratio for a period code
    function automatic logic [23:0] prescale_of(input logic [4:0] code);
        if (code <= `WDT_PERIOD_MAX) begin
            prescale_of = `WDT_PRESCALE_MIN << code;
        end else begin
            prescale_of = `WDT_PRESCALE_MIN;
        end
    endfunction : prescale_of

    // Watchdog activity for mode, software enable and sleep state
    function automatic logic active_of(input logic [1:0] mode, input logic sw_en, input logic asleep);
        case (mode)
            `WDT_MODE_ALWAYS:       active_of = 1'b1;
            `WDT_MODE_NOT_IN_SLEEP: active_of = !asleep;
            `WDT_MODE_SOFTWARE:     active_of = sw_en;
            default:                active_of = 1'b0;
        endcase
    endfunction : active_of

    always_comb begin
        irq_pending = |(IRQ_FLAGS & IRQ_ENABLES);
        ext_reset   = EXTERNAL_RESET_PIN && EXTERNAL_RESET_EN;
        hard_reset  = POWERON_RESET || (BROWNOUT_RESET && BROWNOUT_RESET_EN);
        any_reset   = hard_reset || ext_reset;
        sleep_nop   = irq_pending && !GLOBAL_IRQ_ENABLE;
        prescale    = prescale_of(s.period_sel);
        wdt_active  = active_of(WATCHDOG_MODE_CFG, s.sw_enable, s.st != sleep_wdt_pkg::ST_AWAKE);
        // Time base is the low-frequency tick only
        wdt_timeout = wdt_active && LOW_FREQ_OSC_TICK && (s.wdt_cnt == prescale - 24'h000001);

        next_s          = s;
        next_s.dev_rst  = 1'b0;
        next_s.wake     = 1'b0;
        next_s.isr_call = 1'b0;
        next_s.rdata    = 8'h00;
        next_s.osc_run  = 1'b1;

        // Pads follow the core only while awake
        if (s.st == sleep_wdt_pkg::ST_AWAKE) begin
            next_s.io_out = IO_OUT_CORE;
            next_s.io_oe  = IO_OE_CORE;
        end

        if (REG_REQ.wr) begin
            case (REG_REQ.addr)
                `ADDR_WATCHDOG_CONTROL: begin
                    next_s.period_sel = REG_REQ.wdata[`WDC_PERIOD_MSB:`WDC_PERIOD_LSB];
                    next_s.sw_enable  = REG_REQ.wdata[`WDC_SW_ENABLE_BIT];
                end
                `ADDR_CORE_STATUS_FLAGS: begin
                    next_s.arith_flags = REG_REQ.wdata[2:0];
                end
                default: begin
                end
            endcase
        end
        if (REG_REQ.rd) begin
            case (REG_REQ.addr)
                `ADDR_WATCHDOG_CONTROL:  next_s.rdata = {2'h0, s.period_sel, s.sw_enable};
                `ADDR_CORE_STATUS_FLAGS: next_s.rdata = {3'h0, s.timeout_flag, s.power_down_flag, s.arith_flags};
                default:                 next_s.rdata = 8'h00;
            endcase
        end

        case (s.st)
            sleep_wdt_pkg::ST_AWAKE: begin
                // A no-op sleep leaves the watchdog free to expire
                if (SLEEP_EXEC && !sleep_nop) begin
                    // Prefetched instruction runs on resume
                    next_s.st              = sleep_wdt_pkg::ST_SLEEP;
                    next_s.power_down_flag = 1'b0;
                    next_s.timeout_flag    = 1'b1;
                end else if (CLEAR_WATCHDOG_INSTR_EXEC && !SLEEP_EXEC) begin
                    next_s.timeout_flag    = 1'b1;
                    next_s.power_down_flag = 1'b1;
                end else if (wdt_timeout) begin
                    next_s.dev_rst         = 1'b1;
                    next_s.timeout_flag    = 1'b0;
                    next_s.power_down_flag = 1'b1;
                    next_s.period_sel      = `WDT_PERIOD_DEFAULT;
                    next_s.sw_enable       = 1'b0;
                end
            end
            sleep_wdt_pkg::ST_SLEEP: begin
                if (irq_pending || wdt_timeout) begin
                    if (wdt_timeout) begin
                        next_s.timeout_flag    = 1'b0;
                        next_s.power_down_flag = 1'b0;
                    end
                    if (XTAL_MODE) begin
                        next_s.st      = sleep_wdt_pkg::ST_STARTUP;
                        next_s.ost_cnt = OST_LOAD;
                    end else begin
                        next_s.st       = sleep_wdt_pkg::ST_AWAKE;
                        next_s.wake     = 1'b1;
                        next_s.isr_call = GLOBAL_IRQ_ENABLE && irq_pending;
                    end
                end
            end
            sleep_wdt_pkg::ST_STARTUP: begin
                if (s.ost_cnt == 11'h000) begin
                    next_s.st       = sleep_wdt_pkg::ST_AWAKE;
                    next_s.wake     = 1'b1;
                    next_s.isr_call = GLOBAL_IRQ_ENABLE && irq_pending;
                end else begin
                    next_s.ost_cnt = s.ost_cnt - 11'h001;
                end
            end
            default: begin
                next_s.st = sleep_wdt_pkg::ST_AWAKE;
            end
        endcase

        wdt_clear = !wdt_active
            || (s.st == sleep_wdt_pkg::ST_AWAKE && CLEAR_WATCHDOG_INSTR_EXEC && !SLEEP_EXEC)
            || (s.st == sleep_wdt_pkg::ST_AWAKE && next_s.st == sleep_wdt_pkg::ST_SLEEP)
            || (s.st == sleep_wdt_pkg::ST_SLEEP && next_s.st != sleep_wdt_pkg::ST_SLEEP)
            || OSC_FAIL
            || s.st == sleep_wdt_pkg::ST_STARTUP;
        if (wdt_clear) begin
            next_s.wdt_cnt = 24'h000000;
        end else if (wdt_timeout) begin
            next_s.wdt_cnt = 24'h000000;
        end else if (LOW_FREQ_OSC_TICK) begin
            next_s.wdt_cnt = s.wdt_cnt + 24'h000001;
        end

        // Reset sources act the same awake or asleep
        if (any_reset) begin
            next_s.st         = sleep_wdt_pkg::ST_AWAKE;
            next_s.dev_rst    = 1'b1;
            next_s.wake       = 1'b0;
            next_s.isr_call   = 1'b0;
            next_s.wdt_cnt    = 24'h000000;
            next_s.ost_cnt    = 11'h000;
            next_s.period_sel = `WDT_PERIOD_DEFAULT;
            next_s.sw_enable  = 1'b0;
            if (hard_reset) begin
                next_s.timeout_flag    = 1'b1;
                next_s.power_down_flag = 1'b1;
            end
        end

        next_s.core_clk_en = (next_s.st == sleep_wdt_pkg::ST_AWAKE);
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign REG_RDATA         = s.rdata;
    assign IO_OUT            = s.io_out;
    assign IO_OE             = s.io_oe;
    assign CORE_CLK_EN       = s.core_clk_en;
    assign LOW_FREQ_OSC_RUN  = s.osc_run;
    assign SECONDARY_OSC_RUN = s.osc_run;
    assign DEVICE_RESET      = s.dev_rst;
    assign WAKE              = s.wake;
    assign ISR_CALL          = s.isr_call;
    assign ISR_VECTOR        = `ISR_VECTOR;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    chk_sleep_entry_flags: assert property (
        (s.st == sleep_wdt_pkg::ST_AWAKE && SLEEP_EXEC && !sleep_nop && !any_reset)
        |=> (s.st == sleep_wdt_pkg::ST_SLEEP && !s.power_down_flag && s.timeout_flag && s.wdt_cnt == 24'h000000))
        else $error("sleep entry did not update state and flags");

    chk_sleep_only_instr: assert property (
        (s.st == sleep_wdt_pkg::ST_AWAKE && !SLEEP_EXEC) |=> s.st != sleep_wdt_pkg::ST_SLEEP)
        else $error("sleep entered without sleep instruction");

    chk_sleep_nop_keeps: assert property (
        (s.st == sleep_wdt_pkg::ST_AWAKE && SLEEP_EXEC && sleep_nop && !any_reset)
        |=> (s.st == sleep_wdt_pkg::ST_AWAKE && $stable(s.timeout_flag) && $stable(s.power_down_flag)))
        else $error("sleep with pending interrupt was not a no-op");

    chk_core_clock_stop: assert property (
        CORE_CLK_EN == (s.st == sleep_wdt_pkg::ST_AWAKE) && LOW_FREQ_OSC_RUN && SECONDARY_OSC_RUN)
        else $error("core clock or oscillator run state wrong");

    chk_io_hold_sleep: assert property (
        (s.st == sleep_wdt_pkg::ST_SLEEP && $past(s.st) == sleep_wdt_pkg::ST_SLEEP) |-> ($stable(IO_OUT) && $stable(IO_OE)))
        else $error("port drive changed during sleep");

    chk_wdt_awake_reset: assert property (
        (s.st == sleep_wdt_pkg::ST_AWAKE && wdt_timeout && !(SLEEP_EXEC && !sleep_nop) && !CLEAR_WATCHDOG_INSTR_EXEC && !any_reset)
        |=> (DEVICE_RESET && !s.timeout_flag && s.period_sel == `WDT_PERIOD_DEFAULT))
        else $error("watchdog time-out awake did not reset");

    chk_wdt_sleep_wake: assert property (
        (s.st == sleep_wdt_pkg::ST_SLEEP && wdt_timeout && !any_reset)
        |=> (!DEVICE_RESET && !s.timeout_flag && !s.power_down_flag && s.st != sleep_wdt_pkg::ST_SLEEP))
        else $error("watchdog time-out in sleep mishandled");

    chk_wdt_clear_startup: assert property (
        s.st == sleep_wdt_pkg::ST_STARTUP |-> s.wdt_cnt == 24'h000000)
        else $error("watchdog counted during start-up");

    chk_wdt_off_mode: assert property (
        WATCHDOG_MODE_CFG == `WDT_MODE_OFF |=> (s.wdt_cnt == 24'h000000 && !DEVICE_RESET || any_reset || $past(any_reset)))
        else $error("watchdog counted while disabled");

    chk_startup_holds: assert property (
        (s.st == sleep_wdt_pkg::ST_STARTUP && s.ost_cnt != 11'h000 && !any_reset) |=> s.st == sleep_wdt_pkg::ST_STARTUP)
        else $error("start-up delay cut short");

    chk_irq_wake_vector: assert property (
        (s.st == sleep_wdt_pkg::ST_SLEEP && irq_pending && !XTAL_MODE && !any_reset)
        |=> (WAKE && ISR_CALL == $past(GLOBAL_IRQ_ENABLE) && s.wdt_cnt == 24'h000000))
        else $error("interrupt wake or vector call wrong");

    chk_no_enable_sleep: assert property (
        (s.st == sleep_wdt_pkg::ST_SLEEP && !irq_pending && !wdt_timeout && !any_reset) |=> s.st == sleep_wdt_pkg::ST_SLEEP)
        else $error("woke without enabled source");

    chk_reset_any_state: assert property (
        any_reset |=> (DEVICE_RESET && s.st == sleep_wdt_pkg::ST_AWAKE && s.period_sel == `WDT_PERIOD_DEFAULT))
        else $error("reset source not honoured");

    chk_count_tick_only: assert property (
        (!LOW_FREQ_OSC_TICK && !wdt_clear && !any_reset)
        |=> $stable(s.wdt_cnt))
        else $error("watchdog count moved without a tick");

    chk_osc_fail_clears: assert property (
        OSC_FAIL |=> s.wdt_cnt == 24'h000000)
        else $error("oscillator fail did not clear watchdog");

    chk_clear_instr: assert property (
        (s.st == sleep_wdt_pkg::ST_AWAKE && CLEAR_WATCHDOG_INSTR_EXEC && !SLEEP_EXEC && !any_reset)
        |=> (s.wdt_cnt == 24'h000000 && s.timeout_flag && s.power_down_flag))
        else $error("clear instruction did not clear watchdog");

    chk_sleep_off_mode: assert property (
        (s.st != sleep_wdt_pkg::ST_AWAKE && WATCHDOG_MODE_CFG == `WDT_MODE_NOT_IN_SLEEP)
        |=> s.wdt_cnt == 24'h000000)
        else $error("watchdog counted asleep in awake-only mode");

    chk_pads_follow: assert property (
        s.st == sleep_wdt_pkg::ST_AWAKE
        |=> (IO_OUT == $past(IO_OUT_CORE) && IO_OE == $past(IO_OE_CORE)))
        else $error("port drive did not follow core while awake");

    chk_read_one_cycle: assert property (
        !REG_REQ.rd |=> REG_RDATA == 8'h00)
        else $error("read data stood beyond one cycle");

    cov_sleep_irq_wake: cover property (
        s.st == sleep_wdt_pkg::ST_SLEEP ##1 WAKE);
    cov_startup_done: cover property (
        s.st == sleep_wdt_pkg::ST_STARTUP ##1 s.st == sleep_wdt_pkg::ST_AWAKE);
    cov_sleep_nop: cover property (
        s.st == sleep_wdt_pkg::ST_AWAKE && SLEEP_EXEC && sleep_nop);
    cov_wdt_reset: cover property (
        s.st == sleep_wdt_pkg::ST_AWAKE && wdt_timeout ##1 DEVICE_RESET);
    cov_wdt_sleep_wake: cover property (
        s.st == sleep_wdt_pkg::ST_SLEEP && wdt_timeout ##1 WAKE);

endmodule : sleep_and_watchdog_control

// ===== include/sleep_wdt_defines.svh
// Offsets, field positions, reset values and timing counts of the sleep and watchdog block.
// Assumes a 125 MHz core clock that also serves as the oscillator period for start-up timing.
// Operation
// - Power-down is entered only when the core executes the sleep instruction.
// - Watchdog clears on sleep entry, then keeps counting if its mode allows.
// - Sleep entry clears power_down_flag and sets timeout_flag.
// - Core clock stops in sleep; low_freq_osc and secondary oscillator keep running.
// - All I/O ports hold their pre-sleep drive state during power-down.
// - Non-watchdog reset sources act in sleep exactly as when awake.
// - Wake sources: enabled pin, brown-out, power-on resets; watchdog; enabled interrupts.
// - Interrupt wakes only if individually enabled; global_irq_enable never matters.
// - Wake resumes after sleep; with global_irq_enable, then call vector 0004h.
// - Next instruction is prefetched during sleep; software places a no-op if needed.
// - Watchdog counter clears on every wake, whatever the source.
// - Pending enabled interrupt with global enable clear makes sleep a no-op.
// - Interrupt pending during or after sleep wakes at once, flags updated.
// - Crystal modes delay resumption by 1024 oscillator periods; others do not.
// - Watchdog resets device when clear_watchdog_instr is missed within the period.
// - Watchdog time base is solely the 31 kHz low_freq_osc.
// - Two-bit watchdog_mode_cfg selects the mode; 00 keeps watchdog disabled.
// - Mode 11 keeps watchdog active always, sleep included, ignoring software enable.
// - Mode 10 keeps watchdog active awake, disabled asleep, ignoring software enable.
// - Mode 01 makes watchdog active exactly while sw_watchdog_enable is set.
// - watchdog_period_sel sets 1 ms to 256 s; resets restore two seconds.
// - Counter clears on reset, clear, sleep, wake, oscillator fail, disabled, start-up.
// - Watchdog time-out in sleep wakes the device instead of resetting it.
// - Period code 00000 is 1:32 doubling to 10010; higher codes give 1:32.
`ifndef SLEEP_WDT_DEFINES_SVH
`define SLEEP_WDT_DEFINES_SVH

`define ADDR_WATCHDOG_CONTROL    4'h0
`define ADDR_CORE_STATUS_FLAGS   4'h1

`define WDC_PERIOD_MSB           5
`define WDC_PERIOD_LSB           1
`define WDC_SW_ENABLE_BIT        0
`define CSF_TIMEOUT_BIT          4
`define CSF_POWER_DOWN_BIT       3

`define WDT_PERIOD_DEFAULT       5'h0B
`define WDT_PERIOD_MAX           5'h12
`define WDT_PRESCALE_MIN         24'h000020

`define WDT_MODE_OFF             2'h0
`define WDT_MODE_SOFTWARE        2'h1
`define WDT_MODE_NOT_IN_SLEEP    2'h2
`define WDT_MODE_ALWAYS          2'h3

`define ISR_VECTOR               16'h0004

`define CLK_PERIOD_NS            8
`define OSC_PERIOD_NS            8
`define OST_OSC_PERIODS          1024
`define OST_CYCLES               ((`OST_OSC_PERIODS * `OSC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== include/sleep_wdt_pkg.sv
// Types shared by the sleep and watchdog block and its bench.
// Assumes the constants header supplies every number.
package sleep_wdt_pkg;

    typedef enum logic [1:0] {
        ST_AWAKE,
        ST_SLEEP,
        ST_STARTUP
    } power_state_e;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        power_state_e st;
        logic [23:0]  wdt_cnt;
        logic [10:0]  ost_cnt;
        logic [4:0]   period_sel;
        logic         sw_enable;
        logic         timeout_flag;
        logic         power_down_flag;
        logic [2:0]   arith_flags;
        logic [7:0]   io_out;
        logic [7:0]   io_oe;
        logic [7:0]   rdata;
        logic         dev_rst;
        logic         wake;
        logic         isr_call;
        logic         core_clk_en;
        logic         osc_run;
    } state_s;

endpackage : sleep_wdt_pkg

// ===== tb/core_model.sv
// Model of the processor core that issues sleep and clear instructions and drives the pads.
// Assumes bench requests are one-cycle pulses synchronous to CLK.
`timescale 1ns/1ns

module core_model (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    // Requests from the bench
    input  wire logic       DO_SLEEP,
    input  wire logic       DO_CLR,
    // Block side
    input  wire logic       CORE_CLK_EN,
    output logic            SLEEP_EXEC  = 1'b0,
    output logic            CLEAR_WATCHDOG_INSTR_EXEC = 1'b0,
    output logic [7:0]      IO_OUT_CORE = 8'h00,
    output logic [7:0]      IO_OE_CORE  = 8'h00
);
    always @(posedge CLK) begin
        if (SYS_RST) begin
            SLEEP_EXEC  <= 1'b0;
            CLEAR_WATCHDOG_INSTR_EXEC <= 1'b0;
        end else begin
            // Instructions retire only while the core clock runs
            SLEEP_EXEC  <= DO_SLEEP && CORE_CLK_EN;
            CLEAR_WATCHDOG_INSTR_EXEC <= DO_CLR && CORE_CLK_EN;
        end
        // Pad drive keeps moving so a frozen port shows
        IO_OUT_CORE <= 8'($urandom);
        IO_OE_CORE  <= 8'($urandom);
    end
endmodule : core_model

// ===== tb/sleep_and_watchdog_control_tb.sv
// Self-checking bench for the sleep and watchdog block with a core model beside it.
// Assumes the constants header and package of the design.
`timescale 1ns/1ns
`include "sleep_wdt_defines.svh"

module sleep_and_watchdog_control_tb;
    logic                    CLK = 1'b0, SYS_RST = 1'b1, DO_SLEEP = 1'b0, DO_CLR = 1'b0;
    sleep_wdt_pkg::reg_req_s REG_REQ = '0;
    logic [7:0]              REG_RDATA, IO_OUT, IO_OE, IO_OUT_CORE, IO_OE_CORE, d;
    logic [7:0]              IRQ_FLAGS = 8'h00, IRQ_ENABLES = 8'h00;
    logic                    GLOBAL_IRQ_ENABLE = 1'b0, XTAL_MODE = 1'b0, LOW_FREQ_OSC_TICK = 1'b0, OSC_FAIL = 1'b0;
    logic [1:0]              WATCHDOG_MODE_CFG = 2'h0;
    logic [2:0]              rsrc = 3'h0, rsen = 3'h0;
    logic                    SLEEP_EXEC, CLEAR_WATCHDOG_INSTR_EXEC, CORE_CLK_EN, LOW_FREQ_OSC_RUN, SECONDARY_OSC_RUN;
    logic                    DEVICE_RESET, WAKE, ISR_CALL, isr;
    logic [15:0]             ISR_VECTOR, snap;
    int                      n_mismatch = 0, tests_run = 0, n_rst = 0, n_wake = 0, r0, w0, n;

    always #4 CLK = ~CLK;
    always @(posedge CLK) begin
        n_rst  += int'(DEVICE_RESET === 1'b1);
        n_wake += int'(WAKE === 1'b1);
    end

    core_model core_model_i (.CLK, .SYS_RST, .DO_SLEEP, .DO_CLR, .CORE_CLK_EN, .SLEEP_EXEC, .CLEAR_WATCHDOG_INSTR_EXEC,
        .IO_OUT_CORE, .IO_OE_CORE);
    sleep_and_watchdog_control sleep_and_watchdog_control_i (.CLK, .SYS_RST, .REG_REQ, .REG_RDATA, .SLEEP_EXEC,
        .CLEAR_WATCHDOG_INSTR_EXEC, .IRQ_FLAGS, .IRQ_ENABLES, .GLOBAL_IRQ_ENABLE, .WATCHDOG_MODE_CFG, .XTAL_MODE,
        .LOW_FREQ_OSC_TICK, .OSC_FAIL, .POWERON_RESET(rsrc[0]), .BROWNOUT_RESET(rsrc[1]),
        .BROWNOUT_RESET_EN(rsen[1]), .EXTERNAL_RESET_PIN(rsrc[2]), .EXTERNAL_RESET_EN(rsen[2]), .IO_OUT_CORE,
        .IO_OE_CORE, .IO_OUT, .IO_OE, .CORE_CLK_EN, .LOW_FREQ_OSC_RUN, .SECONDARY_OSC_RUN, .DEVICE_RESET, .WAKE,
        .ISR_CALL, .ISR_VECTOR);

    function automatic int prescale(input logic [4:0] code);
        return (code > `WDT_PERIOD_MAX) ? 32 : (32 << code);
    endfunction : prescale
    function automatic int active(input int m, input int s, input int asleep);
        return int'(m == 3 || (m == 2 && asleep == 0) || (m == 1 && s == 1));
    endfunction : active

    task automatic test_done;
        $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(posedge CLK);
        #1;
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge CLK) REG_REQ <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
        @(posedge CLK) REG_REQ <= '0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge CLK) REG_REQ <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge CLK) REG_REQ <= '0;
        #1 v = REG_RDATA;
    endtask : rd
    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge CLK) LOW_FREQ_OSC_TICK <= 1'b1;
            @(posedge CLK) LOW_FREQ_OSC_TICK <= 1'b0;
        end
        cyc(2);
    endtask : ticks
    task automatic pulse_core(input logic slp);
        @(posedge CLK) if (slp) DO_SLEEP <= 1'b1; else DO_CLR <= 1'b1;
        @(posedge CLK) begin DO_SLEEP <= 1'b0; DO_CLR <= 1'b0; end
        cyc(2);
    endtask : pulse_core
    task automatic go_sleep;
        pulse_core(1'b1);
        check(16'(CORE_CLK_EN), 16'h0000);
    endtask : go_sleep
    task automatic wake_irq(input logic g);
        @(posedge CLK) begin
            GLOBAL_IRQ_ENABLE <= g;
            IRQ_ENABLES <= 8'h01 << ($urandom % 8);
            IRQ_FLAGS <= 8'hFF;
        end
        for (n = 1; n < 3000; n++) begin
            cyc(1);
            if (WAKE === 1'b1) break;
        end
        isr = ISR_CALL;
        @(posedge CLK) IRQ_FLAGS <= 8'h00;
        if (n == 3000) begin n_mismatch++; test_done(); end
    endtask : wake_irq

    initial begin
        void'($urandom(54));
        cyc(12);
        @(posedge CLK) SYS_RST <= 1'b0;
        rd(`ADDR_WATCHDOG_CONTROL, d); check(d, 8'h16);
        rd(`ADDR_CORE_STATUS_FLAGS, d); check(d, 8'h18);
        rd(4'h7, d); check(d, 8'h00);
        wr(`ADDR_WATCHDOG_CONTROL, 8'hD7); wr(`ADDR_CORE_STATUS_FLAGS, 8'hE7); wr(4'h9, 8'h00);
        rd(`ADDR_WATCHDOG_CONTROL, d); check(d, 8'h17);
        rd(`ADDR_CORE_STATUS_FLAGS, d); check(d, 8'h1F);
        // Enabled interrupt pending with global enable clear: sleep is a no-op
        @(posedge CLK) begin IRQ_ENABLES <= 8'h04; IRQ_FLAGS <= 8'h04; end
        pulse_core(1'b1); check(16'(CORE_CLK_EN), 16'h0001);
        rd(`ADDR_CORE_STATUS_FLAGS, d); check(d & 8'h18, 8'h18);
        // Pending with global enable set: sleep completes and wakes at once
        @(posedge CLK) GLOBAL_IRQ_ENABLE <= 1'b1;
        w0 = n_wake; pulse_core(1'b1); cyc(3); check(16'(n_wake - w0), 16'h0001);
        rd(`ADDR_CORE_STATUS_FLAGS, d); check(d & 8'h18, 8'h10);
        @(posedge CLK) IRQ_FLAGS <= 8'h00;
        for (int g = 0; g < 2; g++) begin
            go_sleep(); snap = {IO_OUT, IO_OE};
            check({LOW_FREQ_OSC_RUN, SECONDARY_OSC_RUN}, 16'h0003);
            rd(`ADDR_CORE_STATUS_FLAGS, d); check(d & 8'h18, 8'h10);
            w0 = n_wake; @(posedge CLK) IRQ_FLAGS <= 8'($urandom) & ~IRQ_ENABLES;
            cyc(10); check({IO_OUT, IO_OE}, snap); check(16'(n_wake - w0), 16'h0000);
            wake_irq(g[0]); check(16'(n <= 3), 16'h0001); check(16'(isr), 16'(g));
            check(ISR_VECTOR, `ISR_VECTOR); check(16'(CORE_CLK_EN), 16'h0001);
        end
        XTAL_MODE <= 1'b1; go_sleep(); wake_irq(1'b0); XTAL_MODE <= 1'b0;
        check(16'(n >= `OST_CYCLES && n <= `OST_CYCLES + 6), 16'h0001);
        // Awake time-out for period codes 0, 1 and 1F and one random reserved code from 13 to 1F
        WATCHDOG_MODE_CFG <= 2'h3;
        for (int c = 0; c < 4; c++) begin
            d = (c == 3) ? 8'(5'h13 + $urandom % 13) : 8'(c == 2 ? 5'h1F : c);
            wr(`ADDR_WATCHDOG_CONTROL, {d[4:0], 1'b0}); pulse_core(1'b0); r0 = n_rst;
            ticks(prescale(d[4:0]) - 1); check(16'(n_rst - r0), 16'h0000);
            ticks(1); check(16'(n_rst - r0), 16'h0001);
            rd(`ADDR_CORE_STATUS_FLAGS, d); check(d & 8'h18, 8'h08);
        end
        // Clearing by instruction, oscillator fail, sleep entry and wake
        wr(`ADDR_WATCHDOG_CONTROL, 8'h00); r0 = n_rst; w0 = n_wake;
        ticks(20); pulse_core(1'b0); ticks(20);
        @(posedge CLK) OSC_FAIL <= 1'b1;
        @(posedge CLK) OSC_FAIL <= 1'b0;
        ticks(20); go_sleep(); ticks(20); check(16'(n_rst - r0 + n_wake - w0), 16'h0000);
        ticks(12); check(16'(n_wake - w0), 16'h0001); check(16'(n_rst - r0), 16'h0000);
        rd(`ADDR_CORE_STATUS_FLAGS, d); check(d & 8'h18, 8'h00);
        go_sleep(); ticks(20); wake_irq(1'b0); ticks(31); check(16'(n_rst - r0), 16'h0000);
        // Every mode with both software enables, awake and asleep
        for (int m = 0; m < 4; m++) for (int s = 0; s < 2; s++) begin
            WATCHDOG_MODE_CFG <= 2'(m);
            wr(`ADDR_WATCHDOG_CONTROL, 8'(s)); pulse_core(1'b0); r0 = n_rst;
            ticks(32); check(16'(n_rst - r0), 16'(active(m, s, 0)));
            wr(`ADDR_WATCHDOG_CONTROL, 8'(s)); w0 = n_wake; go_sleep();
            ticks(32); check(16'(n_wake - w0), 16'(active(m, s, 1)));
            check(16'(n_rst - r0), 16'(active(m, s, 0)));
            if (n_wake == w0) wake_irq(1'b0);
        end
        // Reset sources while asleep, with and without their enables
        WATCHDOG_MODE_CFG <= 2'h0;
        for (int i = 0; i < 3; i++) for (int e = 0; e < 2; e++) begin
            go_sleep(); r0 = n_rst;
            @(posedge CLK) begin rsrc[i] <= 1'b1; rsen <= {3{e[0]}}; end
            @(posedge CLK) rsrc <= 3'h0;
            cyc(2); check(16'(n_rst - r0), 16'(i == 0 || e == 1));
            check(16'(CORE_CLK_EN), 16'(i == 0 || e == 1));
            if (n_rst == r0) wake_irq(1'b0);
        end
        test_done();
    end
endmodule : sleep_and_watchdog_control_tb
